// *** core/relative_move_command.sv ***
/*
 sequencer for a relative move command: execute handshake, done, busy,
 active, preempted flag, error with fault code, and hand-off of remaining
 distances from earlier or overlay moves to the axis planner.
 assumes a planner that reports axis status each period, accepts a start
 pulse with a target distance and signals arrival with a done pulse;
 inputs from the user program and planner are on clk_sys.
*/
// Behaviour
// - rising execute starts move; busy next, active one period later
// - falling execute never stops a running move
// - retrigger during execution is ignored
// - after completion, a new edge restarts
// - done rises as busy and active fall
// - done holds until execute falls
// - done pulses one period if execute low
// - preemption raises flag, drops busy and active
// - fault raises error, code; drops busy, active
// - travel adds unfinished positioning remainder
// - final position sums both commanded distances
// - velocity command aborted, move set distance only
// - policy 0, lone overlay: abort, add remainder
// - policy 1-5, lone overlay: error, overlay continues
// - policy 0, overlay with positioning: abort both
// - policy 1-5, overlay with positioning: defer start
module relative_move_command
   import move_pkg::*;
(
   // clock, reset and control period
   input  wire logic          clk_sys,
   input  wire logic          rst_n,
   input  wire logic          period_tick,
   // user program command
   input  wire logic          execute,
   input  move_params_t       cmd_in,
   // axis status and planner events
   input  axis_status_t       axis_in,
   input  wire logic          move_arrived,
   input  wire logic          preempt,
   // planner commands
   output logic               plan_start,
   output logic signed [DIST_W-1:0] plan_distance,
   output move_params_t       plan_params,
   output logic               abort_pos,
   output logic               abort_vel,
   output logic               abort_ovl,
   // user handshake
   output logic               done,
   output logic               busy,
   output logic               active,
   output logic               preempted_flag,
   output logic               error,
   output logic [CODE_W-1:0]  fault_code
);

   seq_state_t   state_q;
   seq_state_t   state_d;
   move_params_t params_q;
   logic         exe_rise;
   logic         exe_fall;
   logic         exe_last;
   logic         legal;
   logic         ovl_alone;
   logic         ovl_with_pos;
   logic         finish;
   logic         abort_ev;
   logic         fault_ev;
   logic [CODE_W-1:0] fault_d;
   logic signed [DIST_W-1:0] base_dist;

   // set distance plus a remainder, cut back to the target width on purpose
   function automatic logic signed [DIST_W-1:0] add_dist(input logic signed [DIST_W-1:0] a,
                                                         input logic signed [DIST_W-1:0] b);
      add_dist = DIST_W'(a + b);
   endfunction

   // execute edges per control period
   edge_detect u_edge (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .tick    (period_tick),
      .level   (execute),
      .rise    (exe_rise),
      .fall    (exe_fall),
      .last    (exe_last)
   );

   // legality of the incoming command
   param_check u_check (
      .p     (cmd_in),
      .legal (legal)
   );

   // overlay situation at the moment of start
   assign ovl_alone    = axis_in.ovl_running & ~axis_in.pos_running;
   assign ovl_with_pos = axis_in.ovl_running & axis_in.pos_running;

   // set distance of a fresh start or of a start deferred in the wait state
   assign base_dist = (state_q == ST_IDLE) ? cmd_in.distance : params_q.distance;

   // move in progress ends by arrival, preemption or axis fault
   assign finish   = (state_q == ST_RUN) && move_arrived;
   assign abort_ev = (state_q != ST_IDLE) && preempt;

   // axis faults and illegal or refused starts
   always_comb begin
      fault_ev = 1'b0;
      fault_d  = FAULT_NONE;
      if (state_q == ST_IDLE && exe_rise) begin
         if (!legal) begin
            fault_ev = 1'b1;
            fault_d  = FAULT_PARAM;
         end else if (ovl_alone && cmd_in.policy != POL_ABORT) begin
            fault_ev = 1'b1;
            fault_d  = FAULT_OVERLAY;
         end
      end
      if (!fault_ev && state_q != ST_IDLE && (axis_in.alarm || axis_in.offline)) begin
         fault_ev = 1'b1;
         fault_d  = axis_in.alarm ? FAULT_ALARM : FAULT_OFFLINE;
      end
      if (!fault_ev && state_q == ST_IDLE && exe_rise && (axis_in.alarm || axis_in.offline)) begin
         fault_ev = 1'b1;
         fault_d  = axis_in.alarm ? FAULT_ALARM : FAULT_OFFLINE;
      end
   end

   // sequencer next state
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         ST_IDLE: begin
            if (period_tick && exe_rise && !fault_ev) begin
               if (cmd_in.policy != POL_ABORT && ovl_with_pos) begin
                  state_d = ST_WAIT;
               end else begin
                  state_d = ST_START;
               end
            end
         end
         ST_WAIT: begin
            if (period_tick) begin
               if (fault_ev || abort_ev) begin
                  state_d = ST_IDLE;
               end else if (!axis_in.pos_running) begin
                  state_d = ST_START;
               end
            end
         end
         ST_START: begin
            if (period_tick) begin
               state_d = (fault_ev || abort_ev) ? ST_IDLE : ST_RUN;
            end
         end
         ST_RUN: begin
            // execute edges are not looked at here
            if (period_tick && (finish || fault_ev || abort_ev)) begin
               state_d = ST_IDLE;
            end
         end
         default: state_d = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= ST_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // capture parameters once per new command
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         params_q <= '0;
      end else if (period_tick && state_q == ST_IDLE && exe_rise) begin
         params_q <= cmd_in;
      end
   end

   // planner start, target distance and aborts of earlier motion
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         plan_start    <= 1'b0;
         plan_distance <= '0;
         plan_params   <= '0;
         abort_pos     <= 1'b0;
         abort_vel     <= 1'b0;
         abort_ovl     <= 1'b0;
      end else begin
         plan_start <= 1'b0;
         abort_pos  <= 1'b0;
         abort_vel  <= 1'b0;
         abort_ovl  <= 1'b0;
         if (period_tick && state_q == ST_IDLE && state_d != ST_IDLE) begin
            plan_params <= cmd_in;
         end
         if (period_tick && state_q != ST_START && state_d == ST_START) begin
            plan_start <= 1'b1;
            abort_vel  <= axis_in.vel_running;
            abort_pos  <= axis_in.pos_running;
            // a deferred start leaves the overlay running untouched
            abort_ovl  <= axis_in.ovl_running && (state_q == ST_IDLE);
            // remainder of unfinished positioning adds in, velocity adds nothing
            if (ovl_alone && state_q == ST_IDLE) begin
               plan_distance <= add_dist(base_dist, axis_in.ovl_remain);
            end else if (axis_in.pos_running) begin
               plan_distance <= add_dist(base_dist, axis_in.pos_remain);
            end else begin
               plan_distance <= base_dist;
            end
         end
      end
   end

   // busy rises with execute, active one period later
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         busy   <= 1'b0;
         active <= 1'b0;
      end else if (period_tick) begin
         busy   <= (state_d != ST_IDLE);
         active <= (state_d == ST_RUN);
      end
   end

   // done: held while execute high, else one period
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         done <= 1'b0;
      end else if (period_tick) begin
         if (finish && !fault_ev && !abort_ev) begin
            done <= 1'b1;
         end else if (exe_rise && state_q == ST_IDLE) begin
            done <= 1'b0;
         end else if (!execute) begin
            done <= 1'b0;
         end
      end
   end

   // preempted flag: held while execute high, else one period
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         preempted_flag <= 1'b0;
      end else if (period_tick) begin
         if (abort_ev && !fault_ev) begin
            preempted_flag <= 1'b1;
         end else if (!execute || (exe_rise && state_q == ST_IDLE)) begin
            preempted_flag <= 1'b0;
         end
      end
   end

   // error and fault code: held while execute high, else one period
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         error      <= 1'b0;
         fault_code <= FAULT_NONE;
      end else if (period_tick) begin
         if (fault_ev) begin
            error      <= 1'b1;
            fault_code <= fault_d;
         end else if (exe_fall || (!execute && !exe_last)) begin
            error      <= 1'b0;
            fault_code <= FAULT_NONE;
         end
      end
   end

endmodule

// *** core/move_pkg.sv ***
/*
 package for the relative move sequencer: widths, policy codes,
 fault codes, states and the sampled command struct.
 assumes nothing beyond a SystemVerilog compiler.
*/
package move_pkg;

   // data widths
   localparam int DIST_W  = 32;
   localparam int RATE_W  = 16;
   localparam int CODE_W  = 16;
   localparam int POL_W   = 3;

   // queueing policy codes
   localparam logic [POL_W-1:0] POL_ABORT = 3'h0;
   localparam logic [POL_W-1:0] POL_MAX   = 3'h5;

   // fault codes, values arbitrary
   localparam logic [CODE_W-1:0] FAULT_NONE    = 16'h0000;
   localparam logic [CODE_W-1:0] FAULT_ALARM   = 16'h0001;
   localparam logic [CODE_W-1:0] FAULT_OFFLINE = 16'h0002;
   localparam logic [CODE_W-1:0] FAULT_PARAM   = 16'h0003;
   localparam logic [CODE_W-1:0] FAULT_OVERLAY = 16'h0004;

   // sequencer states
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_START = 3'b001,
      ST_WAIT  = 3'b010,
      ST_RUN   = 3'b011
   } seq_state_t;

   // command parameters captured at the rising edge of execute
   typedef struct packed {
      logic signed [DIST_W-1:0] distance;
      logic [RATE_W-1:0]        velocity;
      logic [RATE_W-1:0]        accel;
      logic [RATE_W-1:0]        decel;
      logic [RATE_W-1:0]        jerk;
      logic [POL_W-1:0]         policy;
   } move_params_t;

   // state of the axis as reported by the planner
   typedef struct packed {
      logic                     alarm;
      logic                     offline;
      logic                     pos_running;
      logic                     vel_running;
      logic                     ovl_running;
      logic signed [DIST_W-1:0] pos_remain;
      logic signed [DIST_W-1:0] ovl_remain;
   } axis_status_t;

endpackage

// *** core/edge_detect.sv ***
/*
 rising and falling edge detector for a level on the control-period tick.
 assumes the input is already in the clk_sys domain.
*/
module edge_detect
   import move_pkg::*;
(
   // clock and reset
   input  wire logic clk_sys,
   input  wire logic rst_n,
   // sampled level
   input  wire logic tick,
   input  wire logic level,
   // edges, one tick wide, and the level seen at the last tick
   output logic      rise,
   output logic      fall,
   output logic      last
);

   // previous level, updated once per period
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         last <= 1'b0;
      end else if (tick) begin
         last <= level;
      end
   end

   assign rise = level & ~last;
   assign fall = ~level & last;

endmodule

// *** core/param_check.sv ***
/*
 legality check for the sampled command parameters.
 assumes parameters stay stable while checked.
*/
module param_check
   import move_pkg::*;
(
   // parameters under test
   input  move_params_t p,
   // result
   output logic         legal
);

   // rates must be positive, velocity may be zero, policy at most five
   always_comb begin
      legal = (p.accel != '0) && (p.decel != '0) && (p.jerk != '0) && (p.policy <= POL_MAX);
   end

endmodule

// *** tb/move_sva.sv ***
/*
 assertions on the relative move sequencer handshake.
 assumes binding onto relative_move_command with outputs paced by period_tick.
*/
module move_sva
   import move_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // inputs watched
   input wire logic period_tick,
   input wire logic execute,
   input wire logic preempt,
   input wire logic move_arrived,
   input axis_status_t axis_in,
   // outputs watched
   input wire logic plan_start,
   input wire logic signed [DIST_W-1:0] plan_distance,
   input wire logic done,
   input wire logic busy,
   input wire logic active,
   input wire logic preempted_flag,
   input wire logic error,
   input wire logic [CODE_W-1:0] fault_code
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   logic ex_q; // execute seen at the last tick
   // execute level per control period
   always_ff @(posedge clk_sys or negedge rst_n)
      if (!rst_n) ex_q <= 1'b0;
      else if (period_tick) ex_q <= execute;
   // named steps
   sequence s_rise; period_tick && !busy && execute && !ex_q; endsequence
   sequence s_low; period_tick && !execute; endsequence
   sequence s_cut; period_tick && busy && preempt && !move_arrived && !axis_in.alarm && !axis_in.offline; endsequence
   a_start_busy: assert property (s_rise |=> busy || error) else $error("no busy at start");
   a_done_stop: assert property ($rose(done) |-> !busy && !active && $past(busy)) else $error("done late");
   a_done_hold: assert property (done && period_tick && execute && ex_q |=> done) else $error("done lost");
   a_done_clr: assert property (done ##0 s_low |=> !done) else $error("done stuck");
   a_cut_flag: assert property (s_cut |=> preempted_flag && !busy && !active) else $error("no abort");
   a_flag_clr: assert property (preempted_flag ##0 s_low |=> !preempted_flag) else $error("flag stuck");
   a_err_code: assert property ($rose(error) |-> !busy && !active && fault_code != FAULT_NONE) else $error("bad err");
   a_err_clr: assert property (error ##0 s_low |=> !error) else $error("error stuck");
   a_run_held: assert property (active && $past(active) |-> $stable(plan_distance) && !plan_start) else $error("restart");
endmodule
bind relative_move_command move_sva chk_u (.*);

// *** tb/axis_model.sv ***
/*
 behavioural axis and planner facing the move sequencer.
 assumes the bench sets the other motions, faults and the move delay.
*/
module axis_model
   import move_pkg::*;
(
   // clock and pace
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic period_tick,
   // planner commands
   input wire logic plan_start,
   input wire logic signed [DIST_W-1:0] plan_distance,
   input wire logic abort_pos,
   input wire logic abort_vel,
   input wire logic abort_ovl,
   // status back
   output axis_status_t axis_in,
   output logic move_arrived
);
   logic signed [DIST_W-1:0] pos, tgt, prem, orem;
   logic run, prun, vrun, orun, alm, offl;
   int cnt, dly;
   initial {prun, vrun, orun, alm, offl, dly} = '0;
   // idle remainders show junk, not the last value
   assign axis_in = {alm, offl, prun, vrun, orun, prun ? prem : ~prem, orun ? orem : ~orem};
   assign move_arrived = run && cnt == 0;
   // own move: target fixed at start, arrival after dly periods
   always @(posedge clk_sys or negedge rst_n)
      if (!rst_n) begin
         run <= 1'b0;
         pos <= '0;
      end else if (plan_start) begin
         run <= 1'b1;
         tgt <= pos + plan_distance;
         cnt <= dly;
      end else if (run && period_tick) begin
         run <= cnt != 0;
         cnt <= cnt - 1;
         if (cnt == 0) pos <= tgt;
      end
   // aborted motions stop at once
   always @(posedge clk_sys) begin
      if (abort_pos) prun <= 1'b0;
      if (abort_vel) vrun <= 1'b0;
      if (abort_ovl) orun <= 1'b0;
   end
endmodule

// *** tb/relative_move_command_tb_top.sv ***
/*
 self-checking bench for the relative move sequencer.
 assumes axis_model answers planner starts and holds the other motions.
*/
module relative_move_command_tb_top
   import move_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys = 0, rst_n = 0, period_tick = 0, execute = 0, preempt = 0;
   logic plan_start, abort_pos, abort_vel, abort_ovl, move_arrived;
   logic done, busy, active, preempted_flag, error;
   logic signed [DIST_W-1:0] plan_distance;
   logic [CODE_W-1:0] fault_code;
   move_params_t cmd_in, plan_params;
   axis_status_t axis_in;
   int errors = 0, checks_done = 0;
   relative_move_command dut_u (.*);
   axis_model pm (.*);
   always #20 clk_sys = ~clk_sys;
   // control period every second clock
   always @(posedge clk_sys) period_tick <= #2 ~period_tick;
   task automatic tk(input int n);
      repeat (n) @(posedge clk_sys iff period_tick);
      #2;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic go(input logic signed [31:0] d, input logic [2:0] p);
      cmd_in.distance = d;
      cmd_in.policy = p;
      execute = 1'b1;
      tk(1);
   endtask
   task automatic wdone;
      for (int i = 0; i < 40 && done !== 1'b1; i++) tk(1);
      chk("done", 1, done);
   endtask
   task automatic drop;
      execute = 1'b0;
      tk(1);
   endtask
   task final_report;
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // watchdog
   initial begin
      #100000;
      errors++;
      final_report();
   end
   initial begin
      cmd_in = {32'sh0, 16'h0010, 16'h0004, 16'h0004, 16'h0002, 3'h0};
      repeat (6) @(posedge clk_sys);
      #2 rst_n = 1'b1;
      pm.dly = 3;
      // plain move with execute held past completion
      go(100, 0);
      chk("busy", 1, busy);
      chk("active", 0, active);
      tk(1);
      chk("active", 1, active);
      wdone();
      chk("busy", 0, busy | active);
      tk(2);
      chk("done held", 1, done);
      drop();
      chk("done clr", 0, done);
      chk("pos", 100, pm.pos);
      // retrigger and early release during a slow move
      pm.dly = 5;
      go(50, 0);
      drop();
      go(7, 0);
      drop();
      wdone();
      chk("pos", 150, pm.pos);
      tk(1);
      chk("done pulse", 0, done);
      // take over an unfinished positioning move
      pm.dly = 1;
      pm.prem = 40;
      pm.prun = 1;
      go(10, 0);
      tk(1);
      chk("dist", 50, plan_distance);
      wdone();
      chk("pos", 200, pm.pos);
      drop();
      // policy 0 against velocity, lone overlay, overlay with positioning
      for (int k = 0; k < 3; k++) begin
         pm.vrun = k == 0;
         pm.orun = k != 0;
         pm.prun = k == 2;
         pm.orem = 5;
         pm.prem = 20;
         go(10, 0);
         tk(1);
         chk("dist", (k == 0) ? 10 : (k == 1) ? 15 : 30, plan_distance);
         chk("others", 0, {pm.vrun, pm.orun, pm.prun});
         wdone();
         drop();
      end
      // lone overlay refused under a queueing policy
      pm.orun = 1;
      go(10, 3);
      chk("err", 1, error);
      chk("code", FAULT_OVERLAY, fault_code);
      chk("ovl", 1, pm.orun);
      drop();
      chk("err clr", 0, error);
      // overlay with positioning waits under a queueing policy
      pm.prun = 1;
      go(10, 1);
      tk(2);
      chk("wait", 2'b10, {busy, active});
      pm.prun = 0;
      wdone();
      chk("dist", 10, plan_distance);
      drop();
      pm.orun = 0;
      // axis faults and an illegal parameter
      for (int k = 0; k < 3; k++) begin
         pm.alm = k == 0;
         pm.offl = k == 1;
         cmd_in.accel = (k == 2) ? 16'h0000 : 16'h0004;
         go(10, 0);
         chk("err", 1, error);
         chk("code", k + 1, fault_code);
         chk("busy", 0, busy | active);
         drop();
      end
      cmd_in.accel = 16'h0004;
      // preemption with execute held, then with execute low
      pm.dly = 5;
      for (int k = 0; k < 2; k++) begin
         go(10, 0);
         execute = k == 0;
         preempt = 1'b1;
         tk(1);
         preempt = 1'b0;
         chk("flag", 1, preempted_flag);
         chk("busy", 0, busy | active);
         tk(1);
         chk("flag", k == 0, preempted_flag);
         drop();
         chk("flag clr", 0, preempted_flag);
      end
      final_report();
   end
endmodule
